// ===== pkg/rrsf_map.vh
// Register offsets, field positions, reset values and opcode constants of the rotate/fill unit.
`ifndef RRSF_MAP_VH
`define RRSF_MAP_VH
// ----------------------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ----------------------------------------------------------------------------
`define RRSF_OFF_CTRL 4'h0
`define RRSF_OFF_INSTR 4'h4
`define RRSF_OFF_STATUS 4'h8
`define RRSF_OFF_RESULT 4'hC
// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define RRSF_CTRL_BANK_LSB 0
`define RRSF_CTRL_BANK_MSB 3
`define RRSF_CTRL_EXT_BIT 8
`define RRSF_CTRL_FSR2_LSB 16
`define RRSF_CTRL_FSR2_MSB 27
`define RRSF_INSTR_F_LSB 0
`define RRSF_INSTR_F_MSB 7
`define RRSF_INSTR_A_BIT 8
`define RRSF_INSTR_D_BIT 9
`define RRSF_INSTR_OP_LSB 10
`define RRSF_INSTR_OP_MSB 15
`define RRSF_STAT_BUSY_BIT 0
`define RRSF_STAT_N_BIT 1
`define RRSF_STAT_Z_BIT 2
`define RRSF_STAT_BADOP_BIT 3
// ----------------------------------------------------------------------------
// Opcode fields (upper six bits of the instruction word)
// ----------------------------------------------------------------------------
`define RRSF_OPC_ROTATE 6'h10
`define RRSF_OPC_FILL 6'h1A
// ----------------------------------------------------------------------------
// Addressing constants and reset values
// ----------------------------------------------------------------------------
`define RRSF_INDEX_LIMIT 8'h5F
`define RRSF_ACCESS_SPLIT 8'h60
`define RRSF_ACCESS_HIGH_BANK 4'hF
`define RRSF_FILL_VALUE 8'hFF
`define RRSF_RST_BANK 4'h0
`define RRSF_RST_W 8'h00
`define RRSF_RST_FSR2 12'h000
`endif

// ===== design/rrsf_dmem.v
// Data memory of 4096 bytes with one write port and a registered read port.
`timescale 1ns/1ns
`default_nettype none
module rrsf_dmem (
    // Clock
    input wire core_clk_i,
    // Read port
    input wire [11:0] rd_addr_i,
    output reg [7:0] rd_data_o,
    // Write port
    input wire wr_en_i,
    input wire [11:0] wr_addr_i,
    input wire [7:0] wr_data_i
);
    reg [7:0] mem_reg [0:4095];

    // ------------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------------
    // No reset on the array so that it maps to block memory.
    always @(posedge core_clk_i) begin
        if (wr_en_i) begin
            mem_reg[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem_reg[rd_addr_i];
    end
endmodule // rrsf_dmem
`default_nettype wire

// ===== design/rrsf_exec.v
// Execution unit for the rotate-right-no-carry and fill-with-ones byte instructions.
// ----------------------------------------------------------------------------
// Behaviour
// - Rotate moves the byte right one place; old bit 0 becomes bit 7; carry kept.
// - Destination bit 0 sends the rotated byte to the accumulator, source untouched.
// - Destination bit 1 writes the rotated byte back to the byte read.
// - Bank bit 0 picks the access bank; bit 1 picks the bank pointer's bank.
// - Bank bit 0 with extended set on: operands up to 95 are indexed offsets.
// ----------------------------------------------------------------------------
//
// Decided for this implementation: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "rrsf_map.vh"
module rrsf_exec (
    // Clock and reset
    input wire core_clk_i,
    input wire rstn_i,
    // Avalon-MM slave
    input wire [3:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    output reg [31:0] avs_readdata_o,
    output reg avs_waitrequest_o,
    // Core state
    output reg [7:0] w_o,
    output reg carry_o
);
    // ------------------------------------------------------------------------
    // State and registers
    // ------------------------------------------------------------------------
    localparam ST_IDLE = 2'b00;
    localparam ST_READ = 2'b01;
    localparam ST_EXEC = 2'b10;
    localparam ST_DONE = 2'b11;

    reg [1:0] state_reg;
    reg [3:0] bank_pointer_reg;
    reg ext_set_reg;
    reg [11:0] fsr2_reg;
    reg [15:0] instr_reg;
    reg flag_n_reg;
    reg flag_z_reg;
    reg bad_op_reg;
    reg [7:0] result_reg;
    reg [11:0] addr_reg;
    reg [7:0] w_next;
    reg mem_we;
    reg [7:0] mem_wdata;
    wire [7:0] mem_rdata;
    wire [7:0] rot_val;

    // Bank bit 0 with extended set gives an indexed literal offset below 0x60.
    function [11:0] eff_addr;
        input [7:0] f;
        input a;
        input ext;
        input [3:0] bank;
        input [11:0] base;
        begin
            if (!a && ext && (f <= `RRSF_INDEX_LIMIT)) begin
                eff_addr = base + {4'h0, f};
            end else if (!a) begin
                eff_addr = (f < `RRSF_ACCESS_SPLIT) ? {4'h0, f}
                                                   : {`RRSF_ACCESS_HIGH_BANK, f};
            end else begin
                eff_addr = {bank, f};
            end
        end
    endfunction

    wire [5:0] op_code = instr_reg[`RRSF_INSTR_OP_MSB:`RRSF_INSTR_OP_LSB];
    wire op_is_rot = (op_code == `RRSF_OPC_ROTATE);
    wire op_is_fill = (op_code == `RRSF_OPC_FILL);
    wire dest_bit = instr_reg[`RRSF_INSTR_D_BIT];

    assign rot_val = {mem_rdata[0], mem_rdata[7:1]};

    rrsf_dmem u_dmem (
        .core_clk_i(core_clk_i),
        .rd_addr_i(addr_reg),
        .rd_data_o(mem_rdata),
        .wr_en_i(mem_we),
        .wr_addr_i(addr_reg),
        .wr_data_i(mem_wdata)
    );

    // ------------------------------------------------------------------------
    // Execute datapath
    // ------------------------------------------------------------------------
    always @* begin
        mem_we = 1'b0;
        mem_wdata = rot_val;
        w_next = w_o;
        if (state_reg == ST_EXEC) begin
            if (op_is_rot) begin
                if (dest_bit) begin
                    mem_we = 1'b1;
                end else begin
                    w_next = rot_val;
                end
            end else if (op_is_fill) begin
                mem_we = 1'b1;
                mem_wdata = `RRSF_FILL_VALUE;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Sequencer and bus slave
    // ------------------------------------------------------------------------
    // A write to the instruction register holds waitrequest until the memory
    // update lands, so software never sees a half-executed instruction.
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg <= ST_IDLE;
            bank_pointer_reg <= `RRSF_RST_BANK;
            ext_set_reg <= 1'b0;
            fsr2_reg <= `RRSF_RST_FSR2;
            instr_reg <= 16'h0000;
            flag_n_reg <= 1'b0;
            flag_z_reg <= 1'b0;
            bad_op_reg <= 1'b0;
            result_reg <= 8'h00;
            addr_reg <= 12'h000;
            w_o <= `RRSF_RST_W;
            carry_o <= 1'b0;
            avs_readdata_o <= 32'h0000_0000;
            avs_waitrequest_o <= 1'b1;
        end else begin
            w_o <= w_next;
            case (state_reg)
                ST_IDLE: begin
                    avs_waitrequest_o <= 1'b1;
                    if (avs_write_i && avs_waitrequest_o) begin
                        if (avs_address_i == `RRSF_OFF_CTRL) begin
                            if (avs_byteenable_i[0]) begin
                                bank_pointer_reg <=
                                    avs_writedata_i[`RRSF_CTRL_BANK_MSB:`RRSF_CTRL_BANK_LSB];
                            end
                            if (avs_byteenable_i[1]) begin
                                ext_set_reg <= avs_writedata_i[`RRSF_CTRL_EXT_BIT];
                            end
                            if (avs_byteenable_i[2] && avs_byteenable_i[3]) begin
                                fsr2_reg <=
                                    avs_writedata_i[`RRSF_CTRL_FSR2_MSB:`RRSF_CTRL_FSR2_LSB];
                            end
                            avs_waitrequest_o <= 1'b0;
                            state_reg <= ST_DONE;
                        end else if (avs_address_i == `RRSF_OFF_INSTR) begin
                            instr_reg <= avs_writedata_i[15:0];
                            addr_reg <= eff_addr(avs_writedata_i[7:0],
                                avs_writedata_i[`RRSF_INSTR_A_BIT], ext_set_reg,
                                bank_pointer_reg, fsr2_reg);
                            state_reg <= ST_READ;
                        end else begin
                            avs_waitrequest_o <= 1'b0;
                            state_reg <= ST_DONE;
                        end
                    end else if (avs_read_i && avs_waitrequest_o) begin
                        case (avs_address_i)
                            `RRSF_OFF_CTRL: avs_readdata_o <= {4'h0, fsr2_reg, 7'h00,
                                ext_set_reg, 4'h0, bank_pointer_reg};
                            `RRSF_OFF_INSTR: avs_readdata_o <= {16'h0000, instr_reg};
                            `RRSF_OFF_STATUS: avs_readdata_o <= {28'h0000000, bad_op_reg,
                                flag_z_reg, flag_n_reg, 1'b0};
                            `RRSF_OFF_RESULT: avs_readdata_o <= {16'h0000, w_o, result_reg};
                            default: avs_readdata_o <= 32'h0000_0000;
                        endcase
                        avs_waitrequest_o <= 1'b0;
                        state_reg <= ST_DONE;
                    end
                end
                ST_READ: begin
                    state_reg <= ST_EXEC;
                end
                ST_EXEC: begin
                    if (op_is_rot) begin
                        result_reg <= rot_val;
                        flag_n_reg <= rot_val[7];
                        flag_z_reg <= (rot_val == 8'h00);
                        bad_op_reg <= 1'b0;
                    end else if (op_is_fill) begin
                        result_reg <= `RRSF_FILL_VALUE;
                        bad_op_reg <= 1'b0;
                    end else begin
                        bad_op_reg <= 1'b1;
                    end
                    avs_waitrequest_o <= 1'b0;
                    state_reg <= ST_DONE;
                end
                ST_DONE: begin
                    avs_waitrequest_o <= 1'b1;
                    state_reg <= ST_IDLE;
                end
                default: begin
                    avs_waitrequest_o <= 1'b1;
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // rrsf_exec
`default_nettype wire

// ===== tb/rrsf_exec_props.sv
// Port checker for the rotate/fill unit.
`timescale 1ns/1ns
`default_nettype none
module rrsf_exec_props (
    input wire core_clk_i,
    input wire rstn_i,
    input wire [3:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    input wire [31:0] avs_readdata_o,
    input wire avs_waitrequest_o,
    input wire [7:0] w_o,
    input wire carry_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    // Only a rotate with destination bit 0 may touch the accumulator.
    wire rot_acc = avs_write_i && avs_address_i == 4'h4 && avs_writedata_i[15:9] == 7'h20;
    wire ans = !avs_waitrequest_o;
    a_carry_kept: assert property (carry_o == 1'b0)
        else $error("carry output moved");
    a_w_rot_only: assert property ($changed(w_o) |-> $past(rot_acc))
        else $error("accumulator changed without a rotate to it");
    a_wait_pulse: assert property (ans |=> avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    a_read_time: assert property ($rose(avs_read_i) |-> ##[1:2] ans)
        else $error("read answer late");
    a_instr_time: assert property ($rose(avs_write_i) && avs_address_i == 4'h4 |-> ##[2:4] ans)
        else $error("instruction answer late");
    a_unmap_zero: assert property (avs_read_i && ans && avs_address_i[1:0] != 2'h0
        |-> avs_readdata_o == 32'h0)
        else $error("unmapped read not zero");
    a_result_w: assert property (avs_read_i && ans && avs_address_i == 4'hC
        |-> avs_readdata_o[15:8] === w_o)
        else $error("result word disagrees with accumulator");
    a_w_kept: assert property (avs_write_i && ans && avs_address_i == 4'h4
        && (avs_writedata_i[15:10] == 6'h1A || avs_writedata_i[15:9] == 7'h21)
        |-> w_o === $past(w_o))
        else $error("accumulator changed by fill or write-back rotate");
    c_rot_acc: cover property (rot_acc && ans);
    c_fill: cover property (avs_write_i && ans && avs_writedata_i[15:10] == 6'h1A);
    c_unmap: cover property (avs_read_i && ans && avs_address_i == 4'h2);
endmodule // rrsf_exec_props
bind rrsf_exec rrsf_exec_props u_props (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .w_o(w_o), .carry_o(carry_o));
`default_nettype wire

// ===== tb/tb_rrsf_exec.sv
// Self-checking testbench for the rotate/fill unit against a byte-level model.
`timescale 1ns/1ns
`default_nettype none
module tb_rrsf_exec;
    logic core_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [3:0] adr = 4'h0;
    logic rd_i = 1'b0;
    logic wr_i = 1'b0;
    logic [31:0] wd = 32'h0;
    wire [31:0] rdat;
    wire wreq;
    wire [7:0] w;
    wire cy;
    int mismatches = 0;
    int cmp_count = 0;
    // Model state; -1 marks a byte or flag the design cannot know yet.
    int mem[4096];
    int mw;
    int mn;
    int mz;
    int mres;
    logic [31:0] seed = 32'd9212;
    logic [31:0] got;
    logic [7:0] ft[8] = '{8'h10, 8'h50, 8'h5F, 8'h60, 8'hF0, 8'hFF, 8'h00, 8'h5E};
    rrsf_exec u_dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .avs_address_i(adr),
        .avs_read_i(rd_i), .avs_write_i(wr_i), .avs_writedata_i(wd),
        .avs_byteenable_i(4'hF), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
        .w_o(w), .carry_o(cy));
    initial begin
        forever #10 core_clk_i = ~core_clk_i;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic ok, input string m);
        cmp_count++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    // Holds the request until the edge that samples waitrequest low.
    task automatic bus(input logic wn, input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        adr <= a;
        wd <= d;
        wr_i <= wn;
        rd_i <= ~wn;
        // Waitrequest is looked at on rising edges only; the answer edge carries read data.
        do begin
            @(posedge core_clk_i);
        end while (wreq !== 1'b0);
        got = rdat;
        wr_i <= 1'b0;
        rd_i <= 1'b0;
    endtask
    task automatic run(input logic [15:0] ins, input logic [3:0] bk, input logic ex,
        input logic [11:0] bs);
        int f;
        int ad;
        int r;
        logic bad;
        f = ins[7:0];
        bad = ins[15:10] != 6'h10 && ins[15:10] != 6'h1A;
        ad = ins[8] ? bk * 256 + f : (f > 95) ? 3840 + f : ex ? (bs + f) % 4096 : f;
        if (ins[15:10] == 6'h1A) begin
            mem[ad] = 255;
            mres = 255;
        end
        if (ins[15:10] == 6'h10) begin
            r = (mem[ad] < 0) ? -1 : (mem[ad] >> 1) | ((mem[ad] & 1) << 7);
            if (ins[9]) mem[ad] = r;
            else mw = r;
            mn = (r < 0) ? -1 : r >> 7;
            mz = (r < 0) ? -1 : (r == 0);
            mres = r;
        end
        bus(1'b1, 4'h0, {4'h0, bs, 7'h0, ex, 4'h0, bk});
        bus(1'b1, 4'h4, {16'h0, ins});
        bus(1'b0, 4'hC, 32'h0);
        if (mw >= 0) chk(got[15:8] === mw[7:0], "accumulator");
        if (mw >= 0) chk(w === mw[7:0], "accumulator port");
        if (mres >= 0) chk(got[7:0] === mres[7:0], "result byte");
        bus(1'b0, 4'h8, 32'h0);
        chk(got[3] === bad, "bad opcode flag");
        if (mn >= 0) chk(got[2:1] === {mz[0], mn[0]}, "flags");
        chk(cy === 1'b0, "carry");
        bus(1'b0, 4'h0, 32'h0);
        chk(got === {4'h0, bs, 7'h0, ex, 4'h0, bk}, "control readback");
        bus(1'b0, 4'h4, 32'h0);
        chk(got === {16'h0, ins}, "instruction readback");
    endtask
    task automatic stop_test();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #1000000;
        mismatches++;
        stop_test();
    end
    initial begin
        logic [31:0] r;
        int k;
        for (k = 0; k < 4096; k++) mem[k] = -1;
        mw = 0;
        mn = 0;
        mz = 0;
        mres = 0;
        repeat (2) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        bus(1'b1, 4'h6, 32'hFFFF_FFFF);
        bus(1'b0, 4'h2, 32'h0);
        chk(got === 32'h0, "unmapped read");
        for (k = 0; k < 400; k++) begin
            if (k == 300) begin
                // Mid-run reset: registers return to rest, the memory keeps its bytes.
                @(posedge core_clk_i);
                rstn_i <= 1'b0;
                repeat (2) @(posedge core_clk_i);
                chk(w === 8'h00 && wreq === 1'b1 && cy === 1'b0 && rdat === 32'h0,
                    "reset values");
                rstn_i <= 1'b1;
                mw = 0;
                mres = 0;
                mn = 0;
                mz = 0;
            end
            r = rnd();
            run({(r[3:0] == 4'h0) ? 6'h3F : r[4] ? 6'h1A : 6'h10, r[6:5], ft[r[10:8]]},
                r[11] ? 4'hF : {3'h0, r[12]}, r[14], r[13] ? 12'h000 : 12'hFA0);
        end
        stop_test();
    end
endmodule // tb_rrsf_exec
`default_nettype wire
